// file: hw/pfc_clk_div.v
// Purpose: config clock divider with rising-edge tick
// Assumes: runs only while enabled, parks low otherwise
// Notes:   tick marks the cycle before config_clock rises
`include "pfc_map.vh"
module pfc_clk_div (
	// clock and reset
	input  wire                 ref_clk,
	input  wire                 reset_n,
	// control
	input  wire                 enable,
	// outputs
	output reg                  config_clock,
	output wire                 tick
);
	reg  [`PFC_CNT_W-1:0] count;
	wire                  wrap;

	assign wrap = (count == `PFC_DIV_HALF - `PFC_ONE16);
	assign tick = enable & wrap & ~config_clock;

	always @(posedge ref_clk) begin
		if (!reset_n || !enable) begin
			count        <= `PFC_ZERO16;
			config_clock <= 1'b0;
		end else if (wrap) begin
			count        <= `PFC_ZERO16;
			config_clock <= ~config_clock;
		end else begin
			count        <= count + `PFC_ONE16;
		end
	end
endmodule

// file: hw/pfc_config_pins.v
// Purpose: active parallel flash configuration loader and config pin control
// Assumes: all pin inputs synchronous to ref_clk; flash is parallel NOR
// Notes:   registers over classic wishbone; weak pull-up shown as a flag
//
// Operation
// - accept bytes or words per selected width
// - upper data lanes tri-stated, user-controlled after active parallel
// - serial modes leave lanes 1..0 tri-stated
// - after fast passive, lanes 7..2 follow dual-purpose
// - drive 24-bit flash address bus
// - flash reset low while flash resets
// - address-valid low in the address phase of each flash access
// - read strobe low during flash read
// - write strobe low during flash write
// - disabled optional pins float with pull-up
// - user start-up clock times initialization
// - init-done undriven before first frame
// - init-done driven low after first frame
// - release init-done and enter user mode in the same cycle
// - optional calibration gating of init-done
// - global output enable low floats I/O
// - global clear low clears block registers
// - config clock output times flash interface
`include "pfc_map.vh"
module pfc_config_pins (
	// clock and reset
	input  wire                  ref_clk,
	input  wire                  reset_n,
	// wishbone register port
	input  wire                  wb_cyc_i,
	input  wire                  wb_stb_i,
	input  wire                  wb_we_i,
	input  wire [`PFC_ADR_W-1:0] wb_adr_i,
	input  wire [3:0]            wb_sel_i,
	input  wire [31:0]           wb_dat_i,
	output wire [31:0]           wb_dat_o,
	output wire                  wb_ack_o,
	// parallel flash
	output reg  [`PFC_FA_W-1:0]  flash_address_bus,
	output reg                   flash_reset_low,
	output reg                   addr_valid_low,
	output reg                   flash_read_strobe_low,
	output reg                   flash_write_strobe_low,
	output wire                  config_clock,
	// shared data lanes
	input  wire [`PFC_DQ_W-1:0]  data_in,
	output reg  [`PFC_DQ_W-1:0]  data_out,
	output wire [`PFC_DQ_W-1:0]  data_oe,
	// optional pins
	input  wire                  startup_clock_in,
	output wire                  init_done_out,
	output wire                  init_done_oe,
	input  wire                  termination_calib_complete,
	input  wire                  global_output_enable,
	input  wire                  global_register_clear_low,
	output wire                  weak_pullup_en,
	// configuration stream
	output reg  [`PFC_DQ_W-1:0]  config_data,
	output reg                   config_data_valid,
	output reg                   user_mode
);
	wire [`PFC_CTRL_W-1:0] ctrl;
	wire [`PFC_FA_W-1:0]   length;
	wire [`PFC_DQ_W-1:0]   user_out;
	wire [`PFC_DQ_W-1:0]   user_oe;
	wire [`PFC_FA_W-1:0]   wr_addr;
	wire [`PFC_DQ_W-1:0]   wr_data;
	wire [31:0]            status;
	wire [1:0]             mode;
	wire                   width16;
	wire                   opt_usrclk;
	wire                   opt_initd;
	wire                   opt_oct;
	wire                   opt_devoe;
	wire                   opt_devclr;
	wire                   dual_user;
	wire                   soft_clear;
	wire                   pins_off;
	wire                   div_en;
	wire                   tick;
	wire                   usr_edge;
	wire                   init_tick;
	wire [`PFC_DQ_W-1:0]   lane_mask;
	reg  [`PFC_ST_W-1:0]   state;
	reg  [`PFC_ST_W-1:0]   next_state;
	reg  [`PFC_CNT_W-1:0]  count;
	reg  [`PFC_FA_W-1:0]   words_left;
	reg                    first_frame_seen;
	reg                    init_low;
	reg                    configuring;
	reg                    configured;
	reg  [1:0]             done_mode;
	reg                    usr_prev;
	reg  [`PFC_DQ_W-1:0]   next_oe;
	reg                    drive_write;

	assign mode       = ctrl[`PFC_CTRL_MODE_HI:`PFC_CTRL_MODE_LO];
	assign width16    = ctrl[`PFC_CTRL_WIDTH16];
	assign opt_usrclk = ctrl[`PFC_CTRL_OPT_USRCLK];
	assign opt_initd  = ctrl[`PFC_CTRL_OPT_INITD];
	assign opt_oct    = ctrl[`PFC_CTRL_OPT_OCT];
	assign opt_devoe  = ctrl[`PFC_CTRL_OPT_DEVOE];
	assign opt_devclr = ctrl[`PFC_CTRL_OPT_DEVCLR];
	assign dual_user  = ctrl[`PFC_CTRL_DUAL_USER];

	// clear is a level, so it also wipes the option bit that enables it: hold it as a pulse
	assign soft_clear = opt_devclr & ~global_register_clear_low;
	assign pins_off   = opt_devoe & ~global_output_enable;

	function [`PFC_DQ_W-1:0] width_mask;
		input w16;
		begin
			width_mask = w16 ? `PFC_AP_LANES : `PFC_LOW_LANES;
		end
	endfunction

	assign lane_mask = width_mask(width16);

	pfc_wb_regs u_regs (
		.ref_clk    (ref_clk),
		.reset_n    (reset_n),
		.soft_clear (soft_clear),
		.wb_cyc_i   (wb_cyc_i),
		.wb_stb_i   (wb_stb_i),
		.wb_we_i    (wb_we_i),
		.wb_adr_i   (wb_adr_i),
		.wb_sel_i   (wb_sel_i),
		.wb_dat_i   (wb_dat_i),
		.wb_dat_o   (wb_dat_o),
		.wb_ack_o   (wb_ack_o),
		.ctrl       (ctrl),
		.length     (length),
		.user_out   (user_out),
		.user_oe    (user_oe),
		.wr_addr    (wr_addr),
		.wr_data    (wr_data),
		.status     (status)
	);

	// divider runs only for flash traffic so the pin is quiet in user mode except during flash writes
	assign div_en = (state == `PFC_S_FRST) || (state == `PFC_S_ADDR) || (state == `PFC_S_WAIT) ||
	                (state == `PFC_S_WR_SET) || (state == `PFC_S_WR_HOLD);

	pfc_clk_div u_div (
		.ref_clk      (ref_clk),
		.reset_n      (reset_n),
		.enable       (div_en),
		.config_clock (config_clock),
		.tick         (tick)
	);

	// start-up clock is sampled; its rising edge paces initialization
	always @(posedge ref_clk) begin
		if (!reset_n)
			usr_prev <= 1'b0;
		else
			usr_prev <= startup_clock_in;
	end

	assign usr_edge  = startup_clock_in & ~usr_prev;
	assign init_tick = opt_usrclk ? usr_edge : 1'b1;

	always @* begin
		next_state = state;
		case (state)
			`PFC_S_IDLE: begin
				if (ctrl[`PFC_CTRL_START]) begin
					if (mode == `PFC_MODE_AP)
						next_state = `PFC_S_FRST;
					else
						next_state = `PFC_S_EXT;
				end else if (ctrl[`PFC_CTRL_WR_GO] && mode == `PFC_MODE_AP) begin
					next_state = `PFC_S_WR_SET;
				end
			end
			`PFC_S_FRST:
				if (count == `PFC_ZERO16)
					next_state = (length == `PFC_ZERO24) ? `PFC_S_INIT : `PFC_S_ADDR;
			`PFC_S_ADDR:
				if (tick)
					next_state = `PFC_S_WAIT;
			`PFC_S_WAIT:
				if (tick && count == `PFC_ZERO16)
					next_state = (words_left == `PFC_ONE24) ? `PFC_S_INIT : `PFC_S_ADDR;
			`PFC_S_EXT:
				next_state = `PFC_S_INIT;
			`PFC_S_INIT:
				if (init_tick && count == `PFC_ZERO16)
					next_state = `PFC_S_OCT;
			`PFC_S_OCT:
				if (!opt_oct || termination_calib_complete)
					next_state = `PFC_S_USER;
			`PFC_S_USER: begin
				if (ctrl[`PFC_CTRL_START])
					next_state = (mode == `PFC_MODE_AP) ? `PFC_S_FRST : `PFC_S_EXT;
				else if (ctrl[`PFC_CTRL_WR_GO] && done_mode == `PFC_MODE_AP)
					next_state = `PFC_S_WR_SET;
			end
			`PFC_S_WR_SET:
				if (tick)
					next_state = `PFC_S_WR_HOLD;
			`PFC_S_WR_HOLD:
				if (tick)
					next_state = configured ? `PFC_S_USER : `PFC_S_IDLE;
			default:
				next_state = `PFC_S_IDLE;
		endcase
	end

	always @(posedge ref_clk) begin
		if (!reset_n || soft_clear) begin
			state             <= `PFC_S_IDLE;
			count             <= `PFC_ZERO16;
			words_left        <= `PFC_ZERO24;
			flash_address_bus <= `PFC_ZERO24;
			first_frame_seen  <= 1'b0;
			init_low          <= 1'b0;
			configuring       <= 1'b0;
			configured        <= 1'b0;
			done_mode         <= `PFC_MODE_AP;
			config_data       <= `PFC_ZERO16;
			config_data_valid <= 1'b0;
			user_mode         <= 1'b0;
			data_out          <= `PFC_ZERO16;
			drive_write       <= 1'b0;
		end else begin
			state             <= next_state;
			config_data_valid <= 1'b0;
			case (state)
				`PFC_S_IDLE, `PFC_S_USER: begin
					data_out <= user_out;
					if (next_state == `PFC_S_FRST || next_state == `PFC_S_EXT) begin
						count             <= `PFC_FRST_CYC;
						words_left        <= length;
						flash_address_bus <= `PFC_ZERO24;
						first_frame_seen  <= 1'b0;
						init_low          <= 1'b0;
						configuring       <= 1'b1;
						configured        <= 1'b0;
						user_mode         <= 1'b0;
						done_mode         <= mode;
					end else if (next_state == `PFC_S_WR_SET) begin
						flash_address_bus <= wr_addr;
						data_out          <= wr_data & lane_mask;
						drive_write       <= 1'b1;
					end
				end
				`PFC_S_FRST:
					if (count != `PFC_ZERO16)
						count <= count - `PFC_ONE16;
					else
						count <= `PFC_WAIT_TICKS;
				`PFC_S_ADDR:
					if (tick)
						count <= `PFC_WAIT_TICKS;
				`PFC_S_WAIT:
					if (tick) begin
						if (count != `PFC_ZERO16) begin
							count <= count - `PFC_ONE16;
						end else begin
							config_data       <= data_in & lane_mask;
							config_data_valid <= 1'b1;
							flash_address_bus <= flash_address_bus + `PFC_ONE24;
							words_left        <= words_left - `PFC_ONE24;
							count             <= `PFC_INIT_TICKS;
							first_frame_seen  <= 1'b1;
							if (opt_initd)
								init_low <= 1'b1;
						end
					end
				`PFC_S_EXT: begin
					count <= `PFC_INIT_TICKS;
					if (opt_initd)
						init_low <= 1'b1;
				end
				`PFC_S_INIT:
					if (init_tick && count != `PFC_ZERO16)
						count <= count - `PFC_ONE16;
				`PFC_S_OCT:
					if (next_state == `PFC_S_USER) begin
						init_low    <= 1'b0;
						configuring <= 1'b0;
						configured  <= 1'b1;
						user_mode   <= 1'b1;
					end
				`PFC_S_WR_HOLD:
					if (tick)
						drive_write <= 1'b0;
				default: ;
			endcase
		end
	end

	// flash strobes come from flops so they never glitch on state decode
	always @(posedge ref_clk) begin
		if (!reset_n || soft_clear) begin
			flash_reset_low        <= 1'b1;
			addr_valid_low         <= 1'b1;
			flash_read_strobe_low  <= 1'b1;
			flash_write_strobe_low <= 1'b1;
		end else begin
			flash_reset_low        <= ~(next_state == `PFC_S_FRST);
			addr_valid_low         <= ~(next_state == `PFC_S_ADDR || next_state == `PFC_S_WR_SET);
			flash_read_strobe_low  <= ~(next_state == `PFC_S_ADDR || next_state == `PFC_S_WAIT);
			flash_write_strobe_low <= ~(next_state == `PFC_S_WR_SET || next_state == `PFC_S_WR_HOLD);
		end
	end

	// lane drive: only flash writes and released user lanes ever drive
	always @* begin
		next_oe = `PFC_ZERO16;
		if (drive_write) begin
			next_oe = lane_mask;
		end else if (configuring) begin
			next_oe = `PFC_ZERO16;
		end else if (configured) begin
			case (done_mode)
				`PFC_MODE_AP:  next_oe = user_oe;
				`PFC_MODE_FPP: next_oe = dual_user ? (user_oe & `PFC_FPP_REL_LANES) : `PFC_ZERO16;
				`PFC_MODE_AS:  next_oe = user_oe & `PFC_SER_REL_LANES;
				`PFC_MODE_PS:  next_oe = user_oe & `PFC_SER_REL_LANES;
				default:       next_oe = `PFC_ZERO16;
			endcase
		end
	end

	assign data_oe = pins_off ? `PFC_ZERO16 : next_oe;

	// open drain: only ever pull low, the board pull-up makes the high
	assign init_done_out  = 1'b0;
	assign init_done_oe   = opt_initd & init_low & ~pins_off;
	assign weak_pullup_en = configuring;

	assign status = {16'h0000, 3'h0, user_mode, configuring, configured, first_frame_seen,
	                 init_low, done_mode, termination_calib_complete, 1'b0, state};
endmodule

// file: hw/pfc_map.vh
// Purpose: shared constants of the parallel flash configuration pin block
// Assumes: 40 MHz ref_clk, classic wishbone register port with 32-bit data
// Notes:   definitions only
`ifndef PFC_MAP_VH
`define PFC_MAP_VH

// clock and timing
`define PFC_CLK_MHZ          40
`define PFC_FRST_NS          100
// 100 ns at 40 MHz rounded up, kept at counter width so the load never truncates
`define PFC_FRST_CYC         16'h0004
`define PFC_CNT_W            16
`define PFC_DIV_HALF         16'h0002
`define PFC_WAIT_TICKS       16'h0003
`define PFC_INIT_TICKS       16'h0010

// register byte offsets
`define PFC_ADR_W            8
`define PFC_OFS_CTRL         8'h00
`define PFC_OFS_LENGTH       8'h04
`define PFC_OFS_STATUS       8'h08
`define PFC_OFS_USER_OUT     8'h0C
`define PFC_OFS_USER_OE      8'h10
`define PFC_OFS_WR_ADDR      8'h14
`define PFC_OFS_WR_DATA      8'h18

// control fields
`define PFC_CTRL_START       0
`define PFC_CTRL_MODE_LO     1
`define PFC_CTRL_MODE_HI     2
`define PFC_CTRL_WIDTH16     3
`define PFC_CTRL_OPT_USRCLK  4
`define PFC_CTRL_OPT_INITD   5
`define PFC_CTRL_OPT_OCT     6
`define PFC_CTRL_OPT_DEVOE   7
`define PFC_CTRL_OPT_DEVCLR  8
`define PFC_CTRL_DUAL_USER   9
`define PFC_CTRL_WR_GO       10
`define PFC_CTRL_W           11

// configuration modes
`define PFC_MODE_AP          2'h0
`define PFC_MODE_AS          2'h1
`define PFC_MODE_PS          2'h2
`define PFC_MODE_FPP         2'h3

// sequencer states
`define PFC_ST_W             4
`define PFC_S_IDLE           4'h0
`define PFC_S_FRST           4'h1
`define PFC_S_ADDR           4'h2
`define PFC_S_WAIT           4'h3
`define PFC_S_INIT           4'h4
`define PFC_S_OCT            4'h5
`define PFC_S_USER           4'h6
`define PFC_S_WR_SET         4'h7
`define PFC_S_WR_HOLD        4'h8
`define PFC_S_EXT            4'h9

// widths and fills
`define PFC_FA_W             24
`define PFC_DQ_W             16
`define PFC_ZERO32           32'h0000_0000
`define PFC_ZERO24           24'h00_0000
`define PFC_ZERO16           16'h0000
`define PFC_ONE24            24'h00_0001
`define PFC_ONE16            16'h0001
`define PFC_LOW_LANES        16'h00FF
`define PFC_AP_LANES         16'hFFFF
`define PFC_FPP_REL_LANES    16'h00FC
`define PFC_SER_REL_LANES    16'hFFFC
`define PFC_DQ_HI            15
`define PFC_DQ_LO8           7

`endif

// file: hw/pfc_wb_regs.v
// Purpose: classic wishbone slave holding control and user registers
// Assumes: 32-bit data, one register per aligned word
// Notes:   ack one cycle after strobe; unmapped reads return zero, writes dropped
`include "pfc_map.vh"
module pfc_wb_regs (
	// clock and reset
	input  wire                   ref_clk,
	input  wire                   reset_n,
	input  wire                   soft_clear,
	// wishbone
	input  wire                   wb_cyc_i,
	input  wire                   wb_stb_i,
	input  wire                   wb_we_i,
	input  wire [`PFC_ADR_W-1:0]  wb_adr_i,
	input  wire [3:0]             wb_sel_i,
	input  wire [31:0]            wb_dat_i,
	output reg  [31:0]            wb_dat_o,
	output reg                    wb_ack_o,
	// register contents
	output reg  [`PFC_CTRL_W-1:0] ctrl,
	output reg  [`PFC_FA_W-1:0]   length,
	output reg  [`PFC_DQ_W-1:0]   user_out,
	output reg  [`PFC_DQ_W-1:0]   user_oe,
	output reg  [`PFC_FA_W-1:0]   wr_addr,
	output reg  [`PFC_DQ_W-1:0]   wr_data,
	// status in
	input  wire [31:0]            status
);
	wire        take;
	wire [31:0] merged;
	reg  [31:0] cur;

	function [31:0] lane_merge;
		input [31:0] old;
		input [31:0] din;
		input [3:0]  sel;
		integer      i;
		begin
			for (i = 0; i < 4; i = i + 1)
				lane_merge[i*8 +: 8] = sel[i] ? din[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	always @* begin
		case (wb_adr_i)
			`PFC_OFS_CTRL:     cur = {21'h0, ctrl};
			`PFC_OFS_LENGTH:   cur = {8'h00, length};
			`PFC_OFS_STATUS:   cur = status;
			`PFC_OFS_USER_OUT: cur = {16'h0000, user_out};
			`PFC_OFS_USER_OE:  cur = {16'h0000, user_oe};
			`PFC_OFS_WR_ADDR:  cur = {8'h00, wr_addr};
			`PFC_OFS_WR_DATA:  cur = {16'h0000, wr_data};
			default:           cur = `PFC_ZERO32;
		endcase
	end

	assign merged = lane_merge(cur, wb_dat_i, wb_sel_i);
	assign take   = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	// start and write-go self clear so a read never sees a stale command
	always @(posedge ref_clk) begin
		if (!reset_n || soft_clear) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= `PFC_ZERO32;
			ctrl     <= {`PFC_CTRL_W{1'b0}};
			length   <= `PFC_ZERO24;
			user_out <= `PFC_ZERO16;
			user_oe  <= `PFC_ZERO16;
			wr_addr  <= `PFC_ZERO24;
			wr_data  <= `PFC_ZERO16;
		end else begin
			wb_ack_o <= take;
			ctrl[`PFC_CTRL_START] <= 1'b0;
			ctrl[`PFC_CTRL_WR_GO] <= 1'b0;
			if (take && wb_we_i) begin
				case (wb_adr_i)
					`PFC_OFS_CTRL:     ctrl     <= merged[`PFC_CTRL_W-1:0];
					`PFC_OFS_LENGTH:   length   <= merged[`PFC_FA_W-1:0];
					`PFC_OFS_USER_OUT: user_out <= merged[`PFC_DQ_W-1:0];
					`PFC_OFS_USER_OE:  user_oe  <= merged[`PFC_DQ_W-1:0];
					`PFC_OFS_WR_ADDR:  wr_addr  <= merged[`PFC_FA_W-1:0];
					`PFC_OFS_WR_DATA:  wr_data  <= merged[`PFC_DQ_W-1:0];
					default: ;
				endcase
			end
			if (take && !wb_we_i)
				wb_dat_o <= cur;
		end
	end
endmodule

// file: tb/pfc_config_pins_bench.sv
// Purpose: self-checking bench for the flash configuration pin block
// Assumes: wishbone ack one cycle after request, ref_clk 40 MHz
// Notes:   reset between scenarios keeps each start from idle
`include "pfc_map.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module pfc_config_pins_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        ref_clk = 0, reset_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [7:0]  wb_adr_i = 0;
	logic [3:0]  wb_sel_i = 0;
	logic [31:0] wb_dat_i = 0, rdat;
	logic        startup_clock_in = 0, termination_calib_complete = 0;
	logic        global_output_enable = 1, global_register_clear_low = 1;
	wire  [31:0] wb_dat_o;
	wire         wb_ack_o, flash_reset_low, addr_valid_low, flash_read_strobe_low;
	wire         flash_write_strobe_low, config_clock, init_done_out, init_done_oe;
	wire         weak_pullup_en, config_data_valid, user_mode;
	wire  [23:0] flash_address_bus;
	wire  [15:0] data_in, data_out, data_oe, config_data, flash_dq;
	logic [15:0] cap [8], wd;
	logic [23:0] wa;
	logic        rd_q = 1, pin_q = 1, seen_low, rise_seen, wseen, uclk_run = 0;
	int          n_errors = 0, checks_done = 0, ncap, nrd;
	logic [31:0] mctl [4] = '{32'h0000_0003, 32'h0000_0015, 32'h0000_0207, 32'h0000_0007};
	logic [15:0] moe [4] = '{16'hABCC, 16'hABCC, 16'h00CC, 16'h0000};

	// lanes resolved from both drivers
	assign data_in = (data_oe & data_out) | (~data_oe & flash_dq);
	always #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (uclk_run) startup_clock_in <= ~startup_clock_in;

	pfc_config_pins u_pfc_config_pins (.ref_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .flash_address_bus, .flash_reset_low,
		.addr_valid_low, .flash_read_strobe_low, .flash_write_strobe_low, .config_clock, .data_in,
		.data_out, .data_oe, .startup_clock_in, .init_done_out, .init_done_oe,
		.termination_calib_complete, .global_output_enable, .global_register_clear_low,
		.weak_pullup_en, .config_data, .config_data_valid, .user_mode);
	pfc_flash_model u_pfc_flash_model (.ref_clk, .flash_address_bus, .flash_reset_low,
		.flash_read_strobe_low, .flash_dq);

	// pin watcher: pull-up makes init done rise when released
	always @(posedge ref_clk) begin
		if (config_data_valid === 1'b1) begin
			cap[ncap[2:0]] = config_data;
			ncap++;
		end
		if (rd_q === 1'b1 && flash_read_strobe_low === 1'b0) nrd++;
		rd_q = flash_read_strobe_low;
		if (init_done_oe === 1'b1) seen_low = 1;
		if (!pin_q && init_done_oe === 1'b0) begin
			rise_seen = 1;
			`CHK(user_mode, 1'b1)
		end
		pin_q = !init_done_oe;
		if (flash_write_strobe_low === 1'b0) begin
			wa = flash_address_bus;
			wd = data_out;
			wseen = 1;
		end
	end

	task test_done;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge ref_clk);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		for (i = 0; i < 50; i++) begin
			@(posedge ref_clk);
			if (wb_ack_o === 1'b1) break;
		end
		if (i == 50) n_errors++;
		rdat = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
	endtask

	task wait_um(input int n);
		int i;
		for (i = 0; i < n && user_mode !== 1'b1; i++) @(posedge ref_clk);
		// one more edge so the pin watcher has logged the release first
		@(posedge ref_clk);
		`CHK(user_mode, 1'b1)
	endtask

	task cfg(input logic [31:0] ctl, input logic [31:0] len);
		@(posedge ref_clk);
		reset_n <= 0;
		termination_calib_complete <= 0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1;
		ncap = 0;
		nrd = 0;
		seen_low = 0;
		rise_seen = 0;
		wseen = 0;
		wb(1, 8'h10, 32'h0000_ABCD);
		wb(1, 8'h04, len);
		wb(1, 8'h00, ctl);
	endtask

	initial begin
		#(40000 * 25);
		n_errors++;
		test_done;
	end

	initial begin
		// byte wide read with init done pin
		cfg(32'h0000_0021, 32'h0000_0004);
		wait_um(2000);
		`CHK(ncap, 4)
		for (int k = 0; k < 4; k++) `CHK(cap[k][7:0], k[7:0] ^ 8'h5A)
		`CHK(seen_low, 1'b1)
		`CHK(rise_seen, 1'b1)
		`CHK(data_oe, 16'hABCD)
		`CHK(init_done_out, 1'b0)
		wb(0, 8'h08, 32'h0000_0000);
		`CHK(rdat, 32'h0000_1606)
		// device wide output enable
		wb(1, 8'h00, 32'h0000_0080);
		global_output_enable <= 0;
		repeat (2) @(posedge ref_clk);
		`CHK(data_oe, 16'h0000)
		global_output_enable <= 1;
		repeat (2) @(posedge ref_clk);
		`CHK(data_oe, 16'hABCD)
		// flash write from user mode
		wb(1, 8'h14, 32'h0012_3456);
		wb(1, 8'h18, 32'h0000_BEEF);
		wb(1, 8'h00, 32'h0000_0408);
		for (int i = 0; i < 200 && !(wseen && flash_write_strobe_low); i++) @(posedge ref_clk);
		`CHK(wa, 24'h12_3456)
		`CHK(wd, 16'hBEEF)
		// device wide clear
		wb(1, 8'h00, 32'h0000_0100);
		global_register_clear_low <= 0;
		repeat (3) @(posedge ref_clk);
		`CHK(user_mode, 1'b0)
		global_register_clear_low <= 1;
		wb(0, 8'h10, 32'h0000_0000);
		`CHK(rdat, 32'h0000_0000)
		// word wide read held by calibration gating
		cfg(32'h0000_0049, 32'h0000_0002);
		repeat (400) @(posedge ref_clk);
		`CHK(user_mode, 1'b0)
		`CHK(ncap, 2)
		`CHK(cap[1], 16'hFE5B)
		termination_calib_complete <= 1;
		wait_um(200);
		// serial and fast passive modes, user start-up clock in one
		for (int m = 0; m < 4; m++) begin
			cfg(mctl[m], 32'h0000_0004);
			if (m == 1) begin
				repeat (100) @(posedge ref_clk);
				`CHK(user_mode, 1'b0)
				uclk_run <= 1;
			end
			wait_um(500);
			uclk_run <= 0;
			`CHK(nrd, 0)
			`CHK(data_oe, moe[m])
		end
		test_done;
	end
endmodule

// file: tb/pfc_config_pins_chk.sv
// Purpose: port-level checker for the flash configuration pin block
// Assumes: one ref_clk domain, reset_n synchronous active low
// Notes:   attached by bind to every pfc_config_pins instance
`include "pfc_map.vh"
module pfc_config_pins_chk (
	// clock and reset
	input wire logic                 ref_clk,
	input wire logic                 reset_n,
	// flash side
	input wire logic                 flash_reset_low,
	input wire logic                 addr_valid_low,
	input wire logic                 flash_read_strobe_low,
	input wire logic                 flash_write_strobe_low,
	input wire logic                 config_clock,
	input wire logic [`PFC_DQ_W-1:0] data_oe,
	// status
	input wire logic                 init_done_oe,
	input wire logic                 global_output_enable,
	input wire logic                 weak_pullup_en,
	input wire logic                 config_data_valid,
	input wire logic                 user_mode
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	chk_flash_reset_len: assert property ($fell(flash_reset_low) |-> !flash_reset_low [*5] ##1 flash_reset_low)
		else $error("flash reset pulse length wrong");
	chk_avd_with_access: assert property ($fell(addr_valid_low) |-> ##[0:8] (!flash_read_strobe_low || !flash_write_strobe_low))
		else $error("address valid without access");
	chk_rd_wr_apart: assert property (!(!flash_read_strobe_low && !flash_write_strobe_low))
		else $error("read and write strobes low together");
	chk_write_drives: assert property (!flash_write_strobe_low |-> data_oe[7:0] == 8'hFF)
		else $error("write strobe low with lanes floating");
	chk_cfg_lanes_float: assert property (weak_pullup_en |-> data_oe == 16'h0000)
		else $error("lanes driven while configuring");
	chk_clk_with_read: assert property ($fell(flash_read_strobe_low) |-> ##[0:4] $rose(config_clock))
		else $error("config clock idle during read");
	chk_user_release: assert property ($rose(user_mode) |-> !init_done_oe && !weak_pullup_en)
		else $error("user mode before init done release");
	chk_initd_first_word: assert property ($rose(init_done_oe) && global_output_enable
		|-> config_data_valid || $past(config_data_valid) || $past(config_data_valid, 2))
		else $error("init done low without first word");
	chk_word_pulse: assert property (config_data_valid |=> !config_data_valid)
		else $error("word valid longer than one cycle");

	cov_user: cover property ($rose(user_mode));
	cov_write: cover property ($fell(flash_write_strobe_low));
	cov_initd: cover property ($rose(init_done_oe));
endmodule

bind pfc_config_pins pfc_config_pins_chk u_pfc_config_pins_chk (.ref_clk, .reset_n, .flash_reset_low,
	.addr_valid_low, .flash_read_strobe_low, .flash_write_strobe_low, .config_clock, .data_oe,
	.init_done_oe, .global_output_enable, .weak_pullup_en, .config_data_valid, .user_mode);

// file: tb/pfc_flash_model.sv
// Purpose: behavioural parallel flash answering configuration reads
// Assumes: data word is a fixed function of the low address byte
// Notes:   released bus toggles every cycle so stale data never passes
module pfc_flash_model (
	// clock
	input  wire logic        ref_clk,
	// flash pins
	input  wire logic [23:0] flash_address_bus,
	input  wire logic        flash_reset_low,
	input  wire logic        flash_read_strobe_low,
	output logic      [15:0] flash_dq
);
	initial flash_dq = 16'h0000;
	// one cycle access time, returns address data only while read strobe low
	always @(posedge ref_clk) begin
		if (!flash_read_strobe_low && flash_reset_low)
			flash_dq <= {~flash_address_bus[7:0], flash_address_bus[7:0] ^ 8'h5A};
		else
			flash_dq <= ~flash_dq;
	end
endmodule
